/* verif/qlc_data_pins_bench.sv */
/* Self-checking bench for the quad line data pin control block.
   Assumes the framer model and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module qlc_data_pins_bench;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, q;
  logic mode = 1'h1, mute = 1'h0, rlo = 1'h0, rhi = 1'h0, redge = 1'h0, tedge = 1'h1, e;
  logic run = 1'h0, dual = 1'h0, zeros = 1'h0;
  logic [3:0] code = 4'h0, rxp = 4'h0, rxn = 4'h0, los = 4'h0, acc, accm;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, hw;
  wire logic [3:0] tclk, tpos, tneg, rclk, lpos, lneg, rpos, rneg, lost, tplus, tminus, term;
  wire logic [1:0] cpu;
  int n_fail = 0, check_count = 0;
  initial forever #2.5 pclk = ~pclk;
  qlc_framer fm (.run(run), .rise_samp(tedge), .dual(dual), .zeros(zeros), .code_sel(code),
    .rxp(rxp), .rxn(rxn), .tx_clk(tclk), .tx_pos(tpos), .tx_neg(tneg), .rx_clk(rclk),
    .rx_pos(lpos), .rx_neg(lneg));
  qlc_data_pins dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .control_mode_sel(mode), .receive_mute_pin(mute),
    .rx_resistor_sel_lo(rlo), .rx_resistor_sel_hi(rhi), .rx_clock_edge_sel(redge),
    .tx_clock_edge_sel(tedge), .rx_recovered_clock(rclk), .rx_line_pos(lpos),
    .rx_line_neg(lneg), .rx_los_detect(los), .tx_input_clock(tclk), .tx_pos_rail_in(tpos),
    .tx_neg_rail_in(tneg), .rx_pos_rail_out(rpos), .rx_neg_rail_out(rneg),
    .rx_signal_lost_out(lost), .tx_line_plus(tplus), .tx_line_minus(tminus),
    .rx_term_sel(term), .cpu_bus_type(cpu), .hw_mode_out(hw));
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
    check_count++;
    if (got !== x) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, x, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string nm);
    apb(1'h0, a, 32'h0000_0000);
    chk(nm, x, q);
  endtask
  task automatic t_regs;
    rd(12'h000, 32'h0000_0001, "ctrl reset");
    apb(1'h1, 12'h000, 32'hFFFF_FFFF);
    rd(12'h000, 32'h0000_01F3, "ctrl mask");
    apb(1'h1, 12'h004, 32'hFFFF_FFFF);
    rd(12'h004, 32'h0000_0100, "status");
    rd(12'h008, 32'h0000_0000, "unmapped");
    chk("unmapped err", 32'h0000_0001, e);
    $display("regs done");
  endtask
  task automatic t_pins;
    for (int v = 0; v < 4; v++) begin
      {rhi, rlo} <= v[1:0];
      tick(8);
      chk("term", 32'h0000_0001 << v, term);
      rd(12'h004, 32'h0000_0100 | v << 4, "status res");
    end
    mode <= 1'h0;
    for (int v = 1; v < 3; v++) begin
      {tedge, redge} <= v[1:0];
      tick(8);
      chk("bus type", v, cpu);
      rd(12'h004, 32'h0000_0030 | v << 6, "status host");
    end
    mode <= 1'h1;
    tick(8);
    chk("hw mode", 32'h0000_0001, {cpu, hw});
    $display("pins done");
  endtask
  task automatic t_tx;
    apb(1'h1, 12'h000, 32'h0000_0000);
    dual <= 1'h1;
    for (int s = 0; s < 2; s++) begin
      tedge <= s[0];
      tick(8);
      run <= 1'h1;
      repeat (6) begin
        if (s)
          @(posedge tclk[0]);
        else
          @(negedge tclk[0]);
        tick(6);
        chk("tx plus", tpos, tplus);
        chk("tx minus", tneg, tminus);
      end
      run <= 1'h0;
      tick(30);
    end
    $display("tx done");
  endtask
  task automatic t_code;
    dual <= 1'h0;
    zeros <= 1'h1;
    // Passes 2 and 3 run at the E1 rate; the last pass takes the select from host mode.
    for (int s = 0; s < 5; s++) begin
      mode <= (s != 4);
      apb(1'h1, 12'h000, s == 4 ? 32'h0000_0051 : (s[1] ? 32'h0000_0003 : 32'h0000_0001));
      code <= s[0] ? 4'hA : 4'h5;
      run <= 1'h1;
      repeat (12) @(posedge tclk[0]);
      acc = 4'h0;
      accm = 4'h0;
      repeat (24) begin
        @(posedge tclk[0]);
        tick(6);
        acc = acc | tplus;
        accm = accm | tminus;
      end
      chk("zero fill plus", s[0] ? 4'h5 : 4'hA, acc);
      chk("zero fill minus", s[0] ? 4'h5 : 4'hA, accm);
      run <= 1'h0;
      tick(30);
    end
    mode <= 1'h1;
    $display("code done");
  endtask
  task automatic rx_run;
    run <= 1'h1;
    repeat (4) @(posedge rclk[0]);
    run <= 1'h0;
    tick(30);
  endtask
  task automatic t_rx;
    apb(1'h1, 12'h000, 32'h0000_0000);
    rxp <= 4'hA;
    rxn <= 4'h5;
    mute <= 1'h1;
    rx_run();
    chk("rx rails", 32'h0000_005A, {rneg, rpos});
    los <= 4'h3;
    tick(10);
    chk("muted", 32'h0000_0348, {lost, rneg, rpos});
    los <= 4'h0;
    tick(20);
    chk("loss held", 32'h0000_0003, lost);
    rx_run();
    chk("loss end", 32'h0000_005A, {lost, rneg, rpos});
    mute <= 1'h0;
    tick(8);
    los <= 4'h3;
    tick(10);
    chk("unmuted", 32'h0000_035A, {lost, rneg, rpos});
    mode <= 1'h0;
    apb(1'h1, 12'h000, 32'h0000_0100);
    tick(8);
    chk("host mute", 32'h0000_0348, {lost, rneg, rpos});
    mode <= 1'h1;
    los <= 4'h0;
    rx_run();
    apb(1'h1, 12'h000, 32'h0000_0001);
    code <= 4'hF;
    rxp <= 4'hF;
    rxn <= 4'h0;
    run <= 1'h1;
    repeat (16) @(posedge rclk[0]);
    acc = 4'h0;
    accm = 4'h0;
    repeat (40) begin
      tick(1);
      acc = acc | rneg;
      accm = accm | rpos;
    end
    chk("violation", 32'h0000_000F, acc);
    chk("decoded ones", 32'h0000_000F, accm);
    run <= 1'h0;
    $display("rx done");
  endtask
  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    tick(16);
    presetn <= 1'h1;
    tick(2);
    t_regs();
    t_pins();
    t_tx();
    t_code();
    t_rx();
    wrap_up();
  end
  // The whole run takes some 20 us, so this limit only trips on a hang.
  initial begin
    #200000;
    n_fail++;
    wrap_up();
  end
endmodule
bind qlc_data_pins qlc_chk chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .control_mode_sel(control_mode_sel), .receive_mute_pin(receive_mute_pin),
  .rx_resistor_sel_lo(rx_resistor_sel_lo), .rx_resistor_sel_hi(rx_resistor_sel_hi),
  .rx_clock_edge_sel(rx_clock_edge_sel), .tx_clock_edge_sel(tx_clock_edge_sel),
  .rx_recovered_clock(rx_recovered_clock), .rx_los_detect(rx_los_detect),
  .tx_input_clock(tx_input_clock), .rx_pos_rail_out(rx_pos_rail_out),
  .rx_neg_rail_out(rx_neg_rail_out), .rx_signal_lost_out(rx_signal_lost_out),
  .tx_line_plus(tx_line_plus), .rx_term_sel(rx_term_sel), .cpu_bus_type(cpu_bus_type),
  .hw_mode_out(hw_mode_out));
`default_nettype wire

/* verif/qlc_data_pins_chk.sv */
/* Port checker for the quad line data pin control block.
   Assumes it is bound onto the block, all pins driven from outside. */
`timescale 1ns/1ps
`default_nettype none
module qlc_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic control_mode_sel,
  input wire logic receive_mute_pin,
  input wire logic rx_resistor_sel_lo,
  input wire logic rx_resistor_sel_hi,
  input wire logic rx_clock_edge_sel,
  input wire logic tx_clock_edge_sel,
  input wire logic [3:0] rx_recovered_clock,
  input wire logic [3:0] rx_los_detect,
  input wire logic [3:0] tx_input_clock,
  input wire logic [3:0] rx_pos_rail_out,
  input wire logic [3:0] rx_neg_rail_out,
  input wire logic [3:0] rx_signal_lost_out,
  input wire logic [3:0] tx_line_plus,
  input wire logic [3:0] rx_term_sel,
  input wire logic [1:0] cpu_bus_type,
  input wire logic hw_mode_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic [1:0] res = {rx_resistor_sel_hi, rx_resistor_sel_lo};
  wire logic [2:0] pins = {control_mode_sel, tx_clock_edge_sel, rx_clock_edge_sel};
  a_ready_after_reset: assert property ($past(presetn) |-> pready)
    else $error("pready low after reset");
  a_unmapped_error: assert property (psel && penable |->
    pslverr == !(paddr == 12'h000 || paddr == 12'h004)) else $error("pslverr wrong");
  a_mute_forces_low: assert property (
    (control_mode_sel && receive_mute_pin)[*5] |-> ((rx_pos_rail_out | rx_neg_rail_out)
    & rx_signal_lost_out & $past(rx_signal_lost_out)) == 4'h0) else $error("rails not muted");
  a_term_decode: assert property (
    (presetn && $stable(res))[*5] |-> rx_term_sel == 4'h1 << res) else $error("term wrong");
  a_mode_follow: assert property (
    (presetn && $stable(pins))[*5] |-> hw_mode_out == control_mode_sel)
    else $error("mode wrong");
  a_bus_type: assert property (
    (presetn && $stable(pins))[*5] |-> cpu_bus_type ==
    (control_mode_sel ? 2'h0 : {tx_clock_edge_sel, rx_clock_edge_sel})) else $error("bus type");
  a_loss_rise: assert property (
    (presetn && rx_los_detect[0])[*5] |-> rx_signal_lost_out[0]) else $error("loss late");
  a_loss_hold: assert property (
    (~rx_signal_lost_out & $past(rx_signal_lost_out) & $past(rx_los_detect, 3)) == 4'h0)
    else $error("loss ended early");
  a_tx_edge: assert property (
    control_mode_sel && $changed(tx_line_plus[0]) |-> $past(tx_input_clock[0], 3)
    == tx_clock_edge_sel && $past(tx_input_clock[0], 6) != tx_clock_edge_sel)
    else $error("tx sampled on wrong edge");
  a_rx_edge: assert property (
    $changed(rx_pos_rail_out[2]) |-> $past(rx_recovered_clock[2], 3)
    && !$past(rx_recovered_clock[2], 6)) else $error("rx rail moved off rising edge");
  c_unmapped: cover property (psel && penable && pslverr);
  c_muted: cover property (rx_signal_lost_out[0] && receive_mute_pin);
  c_violation: cover property ($rose(rx_neg_rail_out[1]));
endmodule
`default_nettype wire

/* verif/qlc_framer_model.sv */
/* Framer side: transmit and recovered clocks at 64 ns while run is high, idle low otherwise.
   Assumes the bench changes its controls only while the clocks stand still. */
`timescale 1ns/1ps
`default_nettype none
module qlc_framer (
  input wire logic run,
  input wire logic rise_samp,
  input wire logic dual,
  input wire logic zeros,
  input wire logic [3:0] code_sel,
  input wire logic [3:0] rxp,
  input wire logic [3:0] rxn,
  output logic [3:0] tx_clk,
  output logic [3:0] tx_pos,
  output wire logic [3:0] tx_neg,
  output logic [3:0] rx_clk,
  output logic [3:0] rx_pos,
  output logic [3:0] rx_neg
);
  // Dual rail sends encoded rails, single rail holds the coding select level.
  assign tx_neg = dual ? ~tx_pos : code_sel;
  initial begin
    tx_clk = 4'h0;
    tx_pos = 4'h5;
    forever begin
      #32;
      if (run || tx_clk[0]) begin
        tx_clk = ~tx_clk;
        // Data move on the opposite edge, so it is settled at the sampling one.
        if (tx_clk[0] != rise_samp)
          tx_pos <= #8 (zeros ? 4'h0 : ~tx_pos);
      end
    end
  end
  initial begin
    rx_clk = 4'h0;
    rx_pos = 4'h0;
    rx_neg = 4'h0;
    #13;
    forever begin
      #32;
      if (run || rx_clk[0]) begin
        rx_clk = ~rx_clk;
        if (!rx_clk[0]) begin
          rx_pos <= #8 rxp;
          rx_neg <= #8 rxn;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* verilog/qlc_consts.vh */
/*
 Constants for the quad line data pin control block: register offsets,
 field positions, reset values, line symbol codes and decode tables.
 Assumes inclusion by the design files by bare name only.
*/
`ifndef QLC_CONSTS_VH
`define QLC_CONSTS_VH

`define QLC_NCH 4
`define QLC_PIPE_DEPTH 8

`define QLC_OFF_CTRL 12'h000
`define QLC_OFF_STATUS 12'h004

`define QLC_CTRL_SINGLE_RAIL 0
`define QLC_CTRL_E1_RATE 1
`define QLC_CTRL_AMI_LSB 4
`define QLC_CTRL_AMI_MSB 7
`define QLC_CTRL_MUTE 8
`define QLC_CTRL_RESET 32'h0000_0001
`define QLC_CTRL_WMASK 32'h0000_01F3

`define QLC_ST_LOS_LSB 0
`define QLC_ST_RES_LSB 4
`define QLC_ST_CPU_LSB 6
`define QLC_ST_HW 8

`define QLC_SYM_ZERO 2'h0
`define QLC_SYM_ONE 2'h1
`define QLC_SYM_BIP 2'h2
`define QLC_SYM_VIOL 2'h3

`define QLC_B8ZS_PATTERN 16'h038E
`define QLC_TAP_E1 3
`define QLC_TAP_T1 7

`define QLC_TERM_NONE 4'h1
`define QLC_TERM_240 4'h2
`define QLC_TERM_210 4'h4
`define QLC_TERM_150 4'h8

`endif

/* verilog/qlc_data_pins.v */
/*
 Quad line data pin control: pin synchronisers, per-channel transmit
 line coder, receive line decoder with violation flagging, loss-of-signal
 stretching and muting, termination decode and an APB register slave.
 Assumes every pin input is asynchronous to pclk and that the recovered
 receive clocks and transmit clocks are far slower than pclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "qlc_consts.vh"

module qlc_sync #(
  parameter W = 1
) (
  input wire pclk,
  input wire presetn,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// Functional notes
// - Mute high and loss of signal force both receive rails low.
// - One shared mute control governs all four receive channels.
// - Resistor select pins decode to none, 240, 210 or 150 ohm termination.
// - Edge select high: rail data stable for framer sampling on falling edge.
// - Edge select low: receive rails update on rising recovered clock edge.
// - Transmit edge select high: sample transmit data on rising clock edge.
// - Transmit edge select low: sample transmit data on falling clock edge.
// - Coding select low enables HDB3 at E1 or B8ZS at T1.
// - Coding select high selects plain AMI both directions.
// - Single-rail: framer drives NRZ data, device encodes it onto the line.
// - Dual-rail: framer drives encoded rails, device transmits them unchanged.
// - Host mode reads the two edge select pins as bus type selection.
// - Mode pin high selects hardware mode, low selects host mode.
// - Loss output high at least one recovered clock cycle, whole loss.
// - Single-rail negative rail pulses one cycle per code violation.
module qlc_data_pins (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire control_mode_sel,
  input wire receive_mute_pin,
  input wire rx_resistor_sel_lo,
  input wire rx_resistor_sel_hi,
  input wire rx_clock_edge_sel,
  input wire tx_clock_edge_sel,
  input wire [3:0] rx_recovered_clock,
  input wire [3:0] rx_line_pos,
  input wire [3:0] rx_line_neg,
  input wire [3:0] rx_los_detect,
  input wire [3:0] tx_input_clock,
  input wire [3:0] tx_pos_rail_in,
  input wire [3:0] tx_neg_rail_in,
  output reg [3:0] rx_pos_rail_out,
  output reg [3:0] rx_neg_rail_out,
  output reg [3:0] rx_signal_lost_out,
  output reg [3:0] tx_line_plus,
  output reg [3:0] tx_line_minus,
  output reg [3:0] rx_term_sel,
  output reg [1:0] cpu_bus_type,
  output reg hw_mode_out
);
  wire [5:0] cfg_s;
  wire [3:0] rck_s, rp_s, rn_s, los_s, tck_s, tp_s, tn_s;
  reg [3:0] rck_d_reg, tck_d_reg;
  reg [31:0] ctrl_reg;
  wire hw_mode, mute_s, rcke_s, tcke_s;
  wire single_rail, e1_rate, mute_en;
  wire [3:0] ami_sel;
  reg [31:0] rd_next;

  // Configuration pins are static but still pass two flops.
  qlc_sync #(.W(6)) u_cfg_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({tx_clock_edge_sel, rx_clock_edge_sel, rx_resistor_sel_hi, rx_resistor_sel_lo,
        receive_mute_pin, ~control_mode_sel}),
    .q(cfg_s)
  );
  qlc_sync #(.W(28)) u_ch_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({rx_recovered_clock, rx_line_pos, rx_line_neg, rx_los_detect,
        tx_input_clock, tx_pos_rail_in, tx_neg_rail_in}),
    .q({rck_s, rp_s, rn_s, los_s, tck_s, tp_s, tn_s})
  );

  // The mode pin travels inverted so that reset means hardware mode, like an open pin.
  assign hw_mode = ~cfg_s[0];
  assign mute_s = cfg_s[1];
  assign rcke_s = cfg_s[4];
  assign tcke_s = cfg_s[5];
  assign single_rail = ctrl_reg[`QLC_CTRL_SINGLE_RAIL];
  assign e1_rate = ctrl_reg[`QLC_CTRL_E1_RATE];
  // The coding select shares the negative rail pin in single-rail hardware mode.
  assign ami_sel = hw_mode ? tn_s : ctrl_reg[`QLC_CTRL_AMI_MSB:`QLC_CTRL_AMI_LSB];
  assign mute_en = hw_mode ? mute_s : ctrl_reg[`QLC_CTRL_MUTE];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rck_d_reg <= 4'h0;
      tck_d_reg <= 4'h0;
      rx_term_sel <= `QLC_TERM_NONE;
      cpu_bus_type <= 2'h0;
      hw_mode_out <= 1'b1;
    end else begin
      rck_d_reg <= rck_s;
      tck_d_reg <= tck_s;
      hw_mode_out <= hw_mode;
      case ({cfg_s[3], cfg_s[2]})
        2'b00: rx_term_sel <= `QLC_TERM_NONE;
        2'b01: rx_term_sel <= `QLC_TERM_240;
        2'b10: rx_term_sel <= `QLC_TERM_210;
        default: rx_term_sel <= `QLC_TERM_150;
      endcase
      cpu_bus_type <= hw_mode ? 2'h0 : {tcke_s, rcke_s};
    end
  end

  genvar i;
  generate
    for (i = 0; i < `QLC_NCH; i = i + 1) begin : g_ch
      reg [15:0] enc_reg;
      reg enc_par_reg, tx_pol_reg;
      reg [7:0] dd_reg, dv_reg, dp_reg;
      reg rx_pol_reg, rx_seen_reg, los_edge_reg;
      reg [15:0] enc_next;
      reg [1:0] tx_sym;
      reg [7:0] dd_next, dv_next;
      reg pulse, viol, tap_d, tap_v;
      wire tx_edge, rx_edge;

      // Edge select picks which transmit clock edge samples the data.
      assign tx_edge = tcke_s ? (tck_s[i] & ~tck_d_reg[i]) : (~tck_s[i] & tck_d_reg[i]);
      // Rails always launch on the rising edge, so they are steady at the
      // falling edge whichever edge the framer uses.
      assign rx_edge = rck_s[i] & ~rck_d_reg[i];

      always @* begin
        enc_next = {enc_reg[13:0], (tp_s[i] ? `QLC_SYM_ONE : `QLC_SYM_ZERO)};
        tx_sym = e1_rate ? enc_reg[2*`QLC_TAP_E1 +: 2] : enc_reg[2*`QLC_TAP_T1 +: 2];
        if (!tp_s[i] && !ami_sel[i]) begin
          if (e1_rate && enc_reg[5:0] == 6'h00) begin
            enc_next[1:0] = `QLC_SYM_VIOL;
            if (!enc_par_reg) begin
              enc_next[7:6] = `QLC_SYM_BIP;
            end
          end else if (!e1_rate && enc_reg[13:0] == 14'h0000) begin
            enc_next = `QLC_B8ZS_PATTERN;
          end
        end
        pulse = rp_s[i] | rn_s[i];
        viol = pulse & rx_seen_reg & (rp_s[i] == rx_pol_reg);
        dd_next = {dd_reg[6:0], pulse};
        dv_next = {dv_reg[6:0], viol};
        if (!ami_sel[i] && single_rail) begin
          if (e1_rate && viol && dd_reg[1:0] == 2'b00) begin
            dd_next[3:0] = 4'h0;
            dv_next[3:0] = 4'h0;
          end else if (!e1_rate && pulse && !viol && dv_reg[0] && !dd_reg[1] &&
                       dd_reg[2] && !dv_reg[2] && dv_reg[3] && dd_reg[6:4] == 3'b000 &&
                       rp_s[i] != dp_reg[0]) begin
            dd_next[4:0] = 5'h00;
            dv_next[4:0] = 5'h00;
          end
        end
        tap_d = e1_rate ? dd_reg[`QLC_TAP_E1] : dd_reg[`QLC_TAP_T1];
        tap_v = e1_rate ? dv_reg[`QLC_TAP_E1] : dv_reg[`QLC_TAP_T1];
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          enc_reg <= 16'h0000;
          enc_par_reg <= 1'b0;
          tx_pol_reg <= 1'b0;
          tx_line_plus[i] <= 1'b0;
          tx_line_minus[i] <= 1'b0;
        end else if (tx_edge) begin
          if (single_rail) begin
            enc_reg <= enc_next;
            if (enc_next[1:0] == `QLC_SYM_VIOL) begin
              enc_par_reg <= 1'b0;
            end else if (enc_next[1:0] != `QLC_SYM_ZERO) begin
              enc_par_reg <= ~enc_par_reg;
            end
            // Ones and fill pulses alternate; violations repeat the last sign.
            case (tx_sym)
              `QLC_SYM_ONE, `QLC_SYM_BIP: begin
                tx_line_plus[i] <= ~tx_pol_reg;
                tx_line_minus[i] <= tx_pol_reg;
                tx_pol_reg <= ~tx_pol_reg;
              end
              `QLC_SYM_VIOL: begin
                tx_line_plus[i] <= tx_pol_reg;
                tx_line_minus[i] <= ~tx_pol_reg;
              end
              default: begin
                tx_line_plus[i] <= 1'b0;
                tx_line_minus[i] <= 1'b0;
              end
            endcase
          end else begin
            tx_line_plus[i] <= tp_s[i];
            tx_line_minus[i] <= tn_s[i];
          end
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dd_reg <= 8'h00;
          dv_reg <= 8'h00;
          dp_reg <= 8'h00;
          rx_pol_reg <= 1'b0;
          rx_seen_reg <= 1'b0;
          los_edge_reg <= 1'b0;
          rx_signal_lost_out[i] <= 1'b0;
          rx_pos_rail_out[i] <= 1'b0;
          rx_neg_rail_out[i] <= 1'b0;
        end else begin
          // Loss output is held until a full recovered clock cycle has
          // passed and the detector has cleared.
          if (los_s[i]) begin
            rx_signal_lost_out[i] <= 1'b1;
            if (rx_edge && rx_signal_lost_out[i]) begin
              los_edge_reg <= 1'b1;
            end
          end else if (rx_edge && rx_signal_lost_out[i]) begin
            if (los_edge_reg) begin
              rx_signal_lost_out[i] <= 1'b0;
              los_edge_reg <= 1'b0;
            end else begin
              los_edge_reg <= 1'b1;
            end
          end
          if (rx_edge) begin
            dd_reg <= dd_next;
            dv_reg <= dv_next;
            dp_reg <= {dp_reg[6:0], rp_s[i]};
            if (pulse) begin
              rx_pol_reg <= rp_s[i];
              rx_seen_reg <= 1'b1;
            end
          end
          if (mute_en && (los_s[i] || rx_signal_lost_out[i])) begin
            rx_pos_rail_out[i] <= 1'b0;
            rx_neg_rail_out[i] <= 1'b0;
          end else if (rx_edge) begin
            if (single_rail) begin
              rx_pos_rail_out[i] <= tap_d;
              rx_neg_rail_out[i] <= tap_v;
            end else begin
              rx_pos_rail_out[i] <= rp_s[i];
              rx_neg_rail_out[i] <= rn_s[i];
            end
          end
        end
      end
    end
  endgenerate

  always @* begin
    rd_next = 32'h0000_0000;
    if (paddr == `QLC_OFF_CTRL) begin
      rd_next = ctrl_reg;
    end else if (paddr == `QLC_OFF_STATUS) begin
      rd_next[`QLC_ST_LOS_LSB +: 4] = rx_signal_lost_out;
      rd_next[`QLC_ST_RES_LSB +: 2] = cfg_s[3:2];
      rd_next[`QLC_ST_CPU_LSB +: 2] = cpu_bus_type;
      rd_next[`QLC_ST_HW] = hw_mode;
    end
  end

  // Reads are captured in the setup cycle so the access cycle ends at once.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `QLC_CTRL_RESET;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
        prdata <= rd_next;
        pslverr <= (paddr != `QLC_OFF_CTRL) && (paddr != `QLC_OFF_STATUS);
      end
      if (psel && penable && pready && pwrite && paddr == `QLC_OFF_CTRL) begin
        ctrl_reg <= pwdata & `QLC_CTRL_WMASK;
      end
    end
  end
endmodule
`default_nettype wire
